// ### logic/seq_pkg.sv
package seq_pkg;

  // Action store geometry
  localparam int ACT_PER_AXIS = 300;
  localparam int ACT_WORDS = 4;
  localparam int AXIS_STRIDE = 400;
  localparam int ACT_FIRST = 100;
  localparam int ACT_LAST = 399;
  localparam int DWELL_BASE = 450;
  localparam int ACC_BASE = 460;
  localparam int TABLE_ENTRIES = 10;
  localparam int SPEED_BASE = 900;
  localparam int SPEED_ENTRIES = 100;
  localparam int ROT_ADDR = 402;
  localparam int MAXSPD_ADDR = 411;

  // Flat slot layout of the word memory
  localparam int SLOT_ACT = 0;
  localparam int SLOT_DWELL = 2 * ACT_PER_AXIS * ACT_WORDS;
  localparam int SLOT_ACC = SLOT_DWELL + 2 * TABLE_ENTRIES;
  localparam int SLOT_SPD = SLOT_ACC + 4 * TABLE_ENTRIES;
  localparam int SLOT_ROT = SLOT_SPD + 2 * SPEED_ENTRIES;
  localparam int SLOT_MAX = SLOT_ROT + 2;
  localparam int SLOT_COUNT = SLOT_MAX + 4;

  // Fields of the third and fourth action words
  localparam int SPEED_LSB = 8;
  localparam int DWELL_LSB = 12;
  localparam int ACCSEL_LSB = 8;
  localparam int INTERP_LSB = 6;
  localparam int INC_BIT = 5;
  localparam int SIGN_BIT = 4;
  localparam int ENABLE_BIT = 2;
  localparam int ARCDIR_BIT = 1;
  localparam int COMPL_BIT = 0;

  localparam logic [1:0] INTERP_NONE = 2'h0;
  localparam logic [1:0] INTERP_LINEAR = 2'h1;
  localparam logic [1:0] INTERP_ARC_CENTER = 2'h2;
  localparam logic [1:0] INTERP_ARC_END = 2'h3;

  // Register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TBL_ADDR = 8'h0C;
  localparam logic [7:0] REG_TBL_DATA = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_AXIS_BIT = 1;
  localparam int CTRL_ABORT_BIT = 2;
  localparam int TBL_SEL_LSB = 10;
  localparam logic [9:0] START_RESET = 10'h064;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int RATIO_FRAC = 16;
  localparam logic [5:0] DIV_STEPS = 6'h28;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_SCALE = 3'b010,
    ST_MOVE = 3'b011,
    ST_DWELL = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic axis;
    logic [1:0] interp;
    logic incremental;
    logic negative;
    logic arcCw;
    logic invertVoltage;
    logic [26:0] position;
    logic [23:0] speed;
    logic [23:0] exitSpeed;
    logic [15:0] accelTime;
    logic [15:0] decelTime;
  } move_cmd_t;

endpackage : seq_pkg

// ### logic/positioning_action_sequencer.sv
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module positioning_action_sequencer #(
  parameter logic [15:0] MS_CYCLES = 16'(seq_pkg::MS_CYCLES)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output seq_pkg::move_cmd_t moveCmd,
  output logic moveStart,
  input wire logic moveDone,
  output logic mcodeValid,
  output logic [7:0] mcode,
  output logic busy
);

  if (MS_CYCLES < 16'h0001) begin : g_chk
    $error("MS_CYCLES must be at least one");
  end

  typedef struct packed {
    seq_pkg::seq_state_t fsm;
    logic axis;
    logic [9:0] addr;
    logic busy;
    logic done;
    logic error;
    logic mcodeValid;
    logic [7:0] mcode;
    logic [7:0] pendMcode;
    logic [9:0] startAddr;
    logic [9:0] tblAddr;
    logic [1:0] tblSel;
    logic aphValid;
    logic aphWrite;
    logic [7:0] aphAddr;
    logic [31:0] hrdata;
    seq_pkg::move_cmd_t cmd;
    logic moveStart;
    logic contin;
    logic [15:0] dwellMs;
    logic [15:0] cycCnt;
    logic [15:0] accRaw;
    logic [15:0] decRaw;
    logic [23:0] maxSpd;
    logic [24:0] rem;
    logic [39:0] dvd;
    logic [39:0] quo;
    logic [5:0] divCnt;
  } seq_t;

  seq_t s_reg;
  seq_t s_next;

  // Word store for actions and tables; no reset, software loads it
  logic [15:0] mem [seq_pkg::SLOT_COUNT];
  logic memWe;
  logic [12:0] memSlot;

  function automatic logic [12:0] slotOf(input logic [9:0] a,
                                         input logic [1:0] w);
    int ai;
    int v;
    int ofs;
    logic ok;
    ai = int'(a);
    v = 0;
    ok = 1'b0;
    for (int ax = 0; ax < 2; ax++) begin
      ofs = ax * seq_pkg::AXIS_STRIDE;
      if (ai >= seq_pkg::ACT_FIRST + ofs &&
          ai <= seq_pkg::ACT_LAST + ofs) begin
        v = (ai - seq_pkg::ACT_FIRST - ofs + ax * seq_pkg::ACT_PER_AXIS)
            * seq_pkg::ACT_WORDS + int'(w);
        ok = 1'b1;
      end else if (w == 2'h0 && ai >= seq_pkg::DWELL_BASE + ofs &&
                   ai < seq_pkg::DWELL_BASE + ofs + 10) begin
        v = seq_pkg::SLOT_DWELL + ax * 10 + ai - seq_pkg::DWELL_BASE - ofs;
        ok = 1'b1;
      end else if (w < 2'h2 && ai >= seq_pkg::ACC_BASE + ofs &&
                   ai < seq_pkg::ACC_BASE + ofs + 10) begin
        v = seq_pkg::SLOT_ACC + ax * 20
            + (ai - seq_pkg::ACC_BASE - ofs) * 2 + int'(w);
        ok = 1'b1;
      end else if (w == 2'h0 && ai == seq_pkg::ROT_ADDR + ofs) begin
        v = seq_pkg::SLOT_ROT + ax;
        ok = 1'b1;
      end else if (w < 2'h2 && ai == seq_pkg::MAXSPD_ADDR + ofs) begin
        v = seq_pkg::SLOT_MAX + ax * 2 + int'(w);
        ok = 1'b1;
      end
    end
    if (w < 2'h2 && ai >= seq_pkg::SPEED_BASE &&
        ai < seq_pkg::SPEED_BASE + seq_pkg::SPEED_ENTRIES) begin
      v = seq_pkg::SLOT_SPD + (ai - seq_pkg::SPEED_BASE) * 2 + int'(w);
      ok = 1'b1;
    end
    return {ok, 12'(v)};
  endfunction : slotOf

  function automatic logic [15:0] memRead(input logic [9:0] a,
                                          input logic [1:0] w);
    logic [12:0] sl;
    sl = slotOf(a, w);
    return sl[12] ? mem[sl[11:0]] : 16'h0000;
  endfunction : memRead

  function automatic logic [6:0] bcd2(input logic [7:0] b);
    return 7'(int'(b[7:4]) * 10 + int'(b[3:0]));
  endfunction : bcd2

  function automatic logic [26:0] bcd8(input logic [31:0] b);
    int v;
    v = 0;
    for (int i = 7; i >= 0; i--) begin
      v = v * 10 + int'(b[i*4 +: 4]);
    end
    return 27'(v);
  endfunction : bcd8

  function automatic logic inRange(input logic ax, input logic [9:0] a);
    int lo;
    lo = seq_pkg::ACT_FIRST + (ax ? seq_pkg::AXIS_STRIDE : 0);
    return int'(a) >= lo &&
           int'(a) <= lo + seq_pkg::ACT_LAST - seq_pkg::ACT_FIRST;
  endfunction : inRange

  // Reads for the action under the counter and its tables
  logic [15:0] posHi, posLo, wSpd, wAttr, wNextSpd;
  logic [15:0] maxLo, maxHi, spdLo, spdHi, nxtLo, nxtHi, rotWord;
  logic [9:0] axisOfs, spdAddr, nextSpdAddr, dwellAddr, accAddr, addrInc;
  logic [23:0] spdVal, nextSpdVal, maxVal;
  logic actEnable, actContin, arcMove;

  assign axisOfs = s_reg.axis ? 10'(seq_pkg::AXIS_STRIDE) : 10'h000;
  assign addrInc = s_reg.addr + 10'h001;
  // A process, not assigns: table writes must wake these reads up too
  always_comb begin
    posHi = memRead(s_reg.addr, 2'h0);
    posLo = memRead(s_reg.addr, 2'h1);
    wSpd = memRead(s_reg.addr, 2'h2);
    wAttr = memRead(s_reg.addr, 2'h3);
    wNextSpd = memRead(addrInc, 2'h2);
    maxLo = memRead(10'(seq_pkg::MAXSPD_ADDR) + axisOfs, 2'h0);
    maxHi = memRead(10'(seq_pkg::MAXSPD_ADDR) + axisOfs, 2'h1);
    rotWord = memRead(10'(seq_pkg::ROT_ADDR) + axisOfs, 2'h0);
    spdAddr = 10'(seq_pkg::SPEED_BASE)
              + {3'h0, bcd2(wSpd[seq_pkg::SPEED_LSB +: 8])};
    nextSpdAddr = 10'(seq_pkg::SPEED_BASE)
                  + {3'h0, bcd2(wNextSpd[seq_pkg::SPEED_LSB +: 8])};
    spdLo = memRead(spdAddr, 2'h0);
    spdHi = memRead(spdAddr, 2'h1);
    nxtLo = memRead(nextSpdAddr, 2'h0);
    nxtHi = memRead(nextSpdAddr, 2'h1);
  end
  assign dwellAddr = 10'(seq_pkg::DWELL_BASE) + axisOfs
                     + {6'h00, wAttr[seq_pkg::DWELL_LSB +: 4]};
  assign accAddr = 10'(seq_pkg::ACC_BASE) + axisOfs
                   + {6'h00, wAttr[seq_pkg::ACCSEL_LSB +: 4]};
  assign maxVal = {maxHi[7:0], maxLo};
  // Speeds above the axis maximum are capped, keeping the ratio <= 1
  assign spdVal = clampSpd({spdHi[7:0], spdLo}, maxVal);
  assign nextSpdVal = clampSpd({nxtHi[7:0], nxtLo}, maxVal);
  // Bits 15-04 and 02-00 are decoded; only bit 03 is left unused
  assign actEnable = wAttr[seq_pkg::ENABLE_BIT];
  assign actContin = wAttr[seq_pkg::COMPL_BIT];
  assign arcMove = wAttr[seq_pkg::INTERP_LSB + 1];

  function automatic logic [23:0] clampSpd(input logic [23:0] v,
                                           input logic [23:0] m);
    return (m != 24'h000000 && v > m) ? m : v;
  endfunction : clampSpd

  logic aphTake;
  logic ctrlWr;
  logic [24:0] remShift;
  logic [32:0] accProd;
  logic [32:0] decProd;

  assign aphTake = hsel & htrans[1] & hready;
  assign ctrlWr = s_reg.aphValid & s_reg.aphWrite
                  & (s_reg.aphAddr == seq_pkg::REG_CTRL);
  assign memSlot = slotOf(s_reg.tblAddr, s_reg.tblSel);
  assign memWe = s_reg.aphValid & s_reg.aphWrite & memSlot[12]
                 & (s_reg.aphAddr == seq_pkg::REG_TBL_DATA);
  assign remShift = {s_reg.rem[23:0], s_reg.dvd[39]};
  assign accProd = s_reg.accRaw * s_reg.quo[16:0];
  assign decProd = s_reg.decRaw * s_reg.quo[16:0];

  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memSlot[11:0]] <= hwdata[15:0];
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.moveStart = 1'b0;
    unique case (s_reg.fsm)
      seq_pkg::ST_IDLE: begin
      end
      seq_pkg::ST_FETCH: begin
        if (!inRange(s_reg.axis, s_reg.addr)) begin
          s_next.error = 1'b1;
          s_next.busy = 1'b0;
          s_next.fsm = seq_pkg::ST_IDLE;
        end else if (!actEnable) begin
          s_next.addr = addrInc;
          if (!actContin) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.fsm = seq_pkg::ST_IDLE;
          end
        end else begin
          s_next.cmd.axis = s_reg.axis;
          s_next.cmd.interp = wAttr[seq_pkg::INTERP_LSB +: 2];
          s_next.cmd.incremental = wAttr[seq_pkg::INC_BIT];
          s_next.cmd.negative = wAttr[seq_pkg::SIGN_BIT];
          s_next.cmd.arcCw = wAttr[seq_pkg::ARCDIR_BIT];
          s_next.cmd.invertVoltage = rotWord[0];
          s_next.cmd.position = bcd8({posHi, posLo});
          s_next.cmd.speed = spdVal;
          s_next.cmd.exitSpeed = (actContin && inRange(s_reg.axis, addrInc))
                                 ? nextSpdVal : 24'h000000;
          s_next.contin = actContin;
          s_next.pendMcode = wSpd[7:0];
          s_next.mcodeValid = 1'b0;
          s_next.dwellMs = memRead(dwellAddr, 2'h0);
          s_next.accRaw = memRead(accAddr, 2'h0);
          s_next.decRaw = memRead(accAddr, 2'h1);
          s_next.maxSpd = maxVal;
          if (arcMove || maxVal == 24'h000000) begin
            // Arc moves switch speed at once; no maximum means no scaling
            s_next.cmd.accelTime = arcMove ? 16'h0000
                                   : memRead(accAddr, 2'h0);
            s_next.cmd.decelTime = arcMove ? 16'h0000
                                   : memRead(accAddr, 2'h1);
            s_next.moveStart = 1'b1;
            s_next.fsm = seq_pkg::ST_MOVE;
          end else begin
            s_next.rem = 25'h0000000;
            s_next.dvd = {spdVal, 16'h0000};
            s_next.quo = 40'h0000000000;
            s_next.divCnt = seq_pkg::DIV_STEPS;
            s_next.fsm = seq_pkg::ST_SCALE;
          end
        end
      end
      seq_pkg::ST_SCALE: begin
        // Serial divide keeps the ratio logic small at one bit per cycle
        if (s_reg.divCnt != 6'h00) begin
          s_next.dvd = {s_reg.dvd[38:0], 1'b0};
          if (remShift >= {1'b0, s_reg.maxSpd}) begin
            s_next.rem = remShift - {1'b0, s_reg.maxSpd};
            s_next.quo = {s_reg.quo[38:0], 1'b1};
          end else begin
            s_next.rem = remShift;
            s_next.quo = {s_reg.quo[38:0], 1'b0};
          end
          s_next.divCnt = s_reg.divCnt - 6'h01;
        end else begin
          s_next.cmd.accelTime = accProd[seq_pkg::RATIO_FRAC +: 16];
          s_next.cmd.decelTime = decProd[seq_pkg::RATIO_FRAC +: 16];
          s_next.moveStart = 1'b1;
          s_next.fsm = seq_pkg::ST_MOVE;
        end
      end
      seq_pkg::ST_MOVE: begin
        if (!s_reg.moveStart && moveDone) begin
          s_next.cycCnt = 16'h0000;
          s_next.fsm = seq_pkg::ST_DWELL;
        end
      end
      seq_pkg::ST_DWELL: begin
        if (s_reg.dwellMs != 16'h0000) begin
          if (s_reg.cycCnt == MS_CYCLES - 16'h0001) begin
            s_next.cycCnt = 16'h0000;
            s_next.dwellMs = s_reg.dwellMs - 16'h0001;
          end else begin
            s_next.cycCnt = s_reg.cycCnt + 16'h0001;
          end
        end else begin
          s_next.mcode = s_reg.pendMcode;
          s_next.mcodeValid = 1'b1;
          s_next.addr = addrInc;
          if (s_reg.contin && inRange(s_reg.axis, addrInc)) begin
            s_next.fsm = seq_pkg::ST_FETCH;
          end else begin
            s_next.error = s_reg.contin;
            s_next.busy = 1'b0;
            s_next.done = ~s_reg.contin;
            s_next.fsm = seq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        s_next.fsm = seq_pkg::ST_IDLE;
        s_next.busy = 1'b0;
      end
    endcase

    // Data-phase register writes
    if (ctrlWr && hwdata[seq_pkg::CTRL_ABORT_BIT]) begin
      s_next.fsm = seq_pkg::ST_IDLE;
      s_next.busy = 1'b0;
      s_next.moveStart = 1'b0;
    end else if (ctrlWr && hwdata[seq_pkg::CTRL_START_BIT]
                 && !s_reg.busy) begin
      s_next.axis = hwdata[seq_pkg::CTRL_AXIS_BIT];
      s_next.addr = s_reg.startAddr;
      s_next.busy = 1'b1;
      s_next.done = 1'b0;
      s_next.error = 1'b0;
      s_next.mcodeValid = 1'b0;
      s_next.fsm = seq_pkg::ST_FETCH;
    end
    if (s_reg.aphValid && s_reg.aphWrite) begin
      if (s_reg.aphAddr == seq_pkg::REG_START) begin
        s_next.startAddr = hwdata[9:0];
      end else if (s_reg.aphAddr == seq_pkg::REG_TBL_ADDR) begin
        s_next.tblAddr = hwdata[9:0];
        s_next.tblSel = hwdata[seq_pkg::TBL_SEL_LSB +: 2];
      end
    end

    // Address phase: capture, and prepare read data for the data phase
    s_next.aphValid = aphTake;
    s_next.aphWrite = hwrite;
    s_next.aphAddr = haddr[7:0];
    if (aphTake && !hwrite) begin
      unique case (haddr[7:0])
        seq_pkg::REG_CTRL: s_next.hrdata = {30'h00000000, s_reg.axis, 1'b0};
        seq_pkg::REG_START: s_next.hrdata = {22'h000000, s_reg.startAddr};
        seq_pkg::REG_STATUS: s_next.hrdata = {6'h00, s_reg.addr, s_reg.mcode,
          4'h0, s_reg.error, s_reg.mcodeValid, s_reg.done, s_reg.busy};
        seq_pkg::REG_TBL_ADDR:
          s_next.hrdata = {20'h00000, s_reg.tblSel, s_reg.tblAddr};
        seq_pkg::REG_TBL_DATA:
          s_next.hrdata = {16'h0000, memRead(s_reg.tblAddr, s_reg.tblSel)};
        default: s_next.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.startAddr <= seq_pkg::START_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.hrdata;
  assign moveCmd = s_reg.cmd;
  assign moveStart = s_reg.moveStart;
  assign mcodeValid = s_reg.mcodeValid;
  assign mcode = s_reg.mcode;
  assign busy = s_reg.busy;

endmodule : positioning_action_sequencer

// ### verification/seq_checker.sv
`timescale 1ns/10ps
module seq_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire seq_pkg::move_cmd_t moveCmd,
  input wire logic moveStart,
  input wire logic moveDone,
  input wire logic mcodeValid,
  input wire logic [7:0] mcode,
  input wire logic busy
);
  logic doneSeen;

  // Remembers that the servo loop finished since the last move began
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      doneSeen <= 1'b0;
    end else if (moveStart) begin
      doneSeen <= 1'b0;
    end else if (moveDone) begin
      doneSeen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_move_needs_busy: assert property (moveStart |-> busy)
    else $error("move started while idle");
  a_start_one_cycle: assert property (moveStart |=> !moveStart)
    else $error("move start longer than one cycle");
  a_tag_after_done: assert property ($rose(mcodeValid) |-> doneSeen)
    else $error("tag shown before the move completed");
  a_tag_hidden_move: assert property (moveStart |-> !mcodeValid)
    else $error("tag still shown while a move starts");
  a_tag_stable: assert property (
    mcodeValid && $past(mcodeValid) |-> $stable(mcode))
    else $error("tag changed while shown");
  a_pos_range: assert property (
    moveStart |-> moveCmd.position <= 27'h5F5E0FF)
    else $error("position beyond eight digits");
  a_arc_no_ramp: assert property (moveStart && moveCmd.interp[1]
    |-> moveCmd.accelTime == 16'h0000 && moveCmd.decelTime == 16'h0000)
    else $error("arc move carries a ramp time");
  a_dwell_gap: assert property (moveDone && busy |=> !mcodeValid)
    else $error("tag shown without dwell gap");
  a_cmd_held: assert property (moveStart |=> $stable(moveCmd))
    else $error("move command changed during move");
endmodule : seq_checker

bind positioning_action_sequencer seq_checker u_chk (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .moveCmd(moveCmd), .moveStart(moveStart),
  .moveDone(moveDone), .mcodeValid(mcodeValid), .mcode(mcode),
  .busy(busy)
);

// ### verification/servo_model.sv
`timescale 1ns/10ps
module servo_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic moveStart,
  input wire logic [7:0] latency,
  output logic moveDone
);
  logic running;
  logic [7:0] left;

  // Any latency, zero included, puts the done pulse at least two cycles after the start cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      moveDone <= 1'b0;
      running <= 1'b0;
      left <= 8'h00;
    end else begin
      moveDone <= 1'b0;
      if (moveStart) begin
        running <= 1'b1;
        left <= latency;
      end else if (running) begin
        if (left <= 8'h01) begin
          moveDone <= 1'b1;
          running <= 1'b0;
        end else begin
          left <= left - 8'h01;
        end
      end
    end
  end
endmodule : servo_model

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hready, hreadyout, hresp, moveStart, moveDone, mcodeValid, busy;
  logic [7:0] mcode;
  logic [7:0] latency = 8'h01;
  seq_pkg::move_cmd_t moveCmd;
  int nErrors = 0, checksDone = 0, nMoves = 0;
  logic [9:0] actAddr [7] = '{10'h065, 10'h066, 10'h067, 10'h068, 10'h1F4,
    10'h18F, 10'h31F};
  logic [15:0] actW [7][4] = '{'{16'h0012, 16'h3456, 16'h1237, 16'h173D},
    '{16'h0000, 16'h0001, 16'h1299, 16'h0001},
    '{16'h0000, 16'h0000, 16'h1245, 16'h0786},
    '{16'h0000, 16'h0000, 16'h1211, 16'h0000},
    '{16'h9999, 16'h9999, 16'h0552, 16'h2344},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000}};
  // Entries are {word select, device address, data}
  logic [27:0] prm [17] = '{{2'h0, 10'h192, 16'h0001},
    {2'h0, 10'h322, 16'h0000}, {2'h0, 10'h19B, 16'h0FA0},
    {2'h1, 10'h19B, 16'h0000}, {2'h0, 10'h32B, 16'h0FA0},
    {2'h1, 10'h32B, 16'h0000}, {2'h0, 10'h390, 16'h03E8},
    {2'h1, 10'h390, 16'h0000}, {2'h0, 10'h389, 16'h1770},
    {2'h1, 10'h389, 16'h0000}, {2'h0, 10'h1C2, 16'h0000},
    {2'h0, 10'h1C3, 16'h0002}, {2'h0, 10'h354, 16'h0001},
    {2'h0, 10'h1D3, 16'h00C8}, {2'h1, 10'h1D3, 16'h0064},
    {2'h0, 10'h35F, 16'h0064}, {2'h1, 10'h35F, 16'h0028}};

  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (moveStart === 1'b1) begin
      nMoves <= nMoves + 1;
    end
  end

  positioning_action_sequencer #(.MS_CYCLES(16'h0004)) dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .moveCmd(moveCmd), .moveStart(moveStart),
    .moveDone(moveDone), .mcodeValid(mcodeValid), .mcode(mcode),
    .busy(busy)
  );
  servo_model partner (
    .clk(clk), .resetn(resetn), .moveStart(moveStart),
    .latency(latency), .moveDone(moveDone)
  );

  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : testDone

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // Waits out both bus phases; hreadyout is sampled at each edge
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (k >= 50) begin
      nErrors++;
      testDone();
    end
    htrans <= 2'h0;
    hwdata <= wd;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    rd = hrdata;
    if (k >= 50) begin
      nErrors++;
      testDone();
    end
  endtask : bus

  task automatic put(input logic [1:0] s, input logic [9:0] a,
                     input logic [15:0] d);
    logic [31:0] r;
    bus(seq_pkg::REG_TBL_ADDR, 1'b1, {20'h00000, s, a}, r);
    bus(seq_pkg::REG_TBL_DATA, 1'b1, {16'h0000, d}, r);
  endtask : put

  function automatic logic pick(input int w);
    case (w)
      0: return moveStart;
      1: return moveDone;
      2: return mcodeValid;
      default: return ~busy;
    endcase
  endfunction : pick

  task automatic waitEv(input int w, output int n);
    for (n = 0; n < 3000 && pick(w) !== 1'b1; n++) begin
      tick();
    end
    if (n >= 3000) begin
      nErrors++;
      $display("wrong value wait %0d expected 1 seen 0", w);
      testDone();
    end
  endtask : waitEv

  task automatic checkMove(input logic [6:0] f, input logic [31:0] p, sp,
                           ex, ac, dc);
    check("flags", 32'(f), 32'({moveCmd.axis, moveCmd.interp,
      moveCmd.incremental, moveCmd.negative, moveCmd.arcCw,
      moveCmd.invertVoltage}));
    check("position", p, 32'(moveCmd.position));
    check("speed", sp, 32'(moveCmd.speed));
    check("exit speed", ex, 32'(moveCmd.exitSpeed));
    check("accel", ac, 32'(moveCmd.accelTime));
    check("decel", dc, 32'(moveCmd.decelTime));
  endtask : checkMove

  task automatic runFrom(input logic [9:0] a, input logic axis);
    logic [31:0] r;
    bus(seq_pkg::REG_START, 1'b1, {22'h000000, a}, r);
    bus(seq_pkg::REG_CTRL, 1'b1, {30'h00000000, axis, 1'b1}, r);
  endtask : runFrom

  initial begin
    logic [31:0] r;
    int n;
    int m;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    tick();
    check("busy", 32'h0, 32'(busy));
    check("tag valid", 32'h0, 32'(mcodeValid));
    bus(seq_pkg::REG_START, 1'b0, 32'h0, r);
    check("start reset", 32'(seq_pkg::START_RESET), 32'(r[9:0]));
    bus(8'h20, 1'b1, 32'hFFFFFFFF, r);
    bus(8'h20, 1'b0, 32'h0, r);
    check("unmapped", 32'h0, r);
    foreach (prm[i]) put(prm[i][27:26], prm[i][25:16], prm[i][15:0]);
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 4; j++) begin
        put(2'(j), actAddr[i], actW[i][j]);
      end
    end
    bus(seq_pkg::REG_TBL_ADDR, 1'b1, 32'h00000DF4, r);
    bus(seq_pkg::REG_TBL_DATA, 1'b0, 32'h0, r);
    check("stored word", 32'h2344, r);
    runFrom(10'h065, 1'b0);
    waitEv(0, n);
    checkMove(7'h0D, 32'h1E240, 32'h3E8, 32'h3E8, 32'h32, 32'h19);
    waitEv(1, n);
    waitEv(2, n);
    check("dwell gap", 32'hA, 32'(n));
    check("tag", 32'h37, 32'(mcode));
    waitEv(0, n);
    checkMove(7'h23, 32'h0, 32'h3E8, 32'h0, 32'h0, 32'h0);
    waitEv(2, n);
    check("tag", 32'h45, 32'(mcode));
    waitEv(3, n);
    bus(seq_pkg::REG_STATUS, 1'b0, 32'h0, r);
    check("counter", 32'h68, 32'(r[25:16]));
    check("status", 32'h2, 32'(r[1:0]));
    check("status tag", 32'h45, 32'(r[15:8]));
    m = nMoves;
    runFrom(10'h068, 1'b0);
    tick();
    waitEv(3, n);
    bus(seq_pkg::REG_STATUS, 1'b0, 32'h0, r);
    check("counter", 32'h69, 32'(r[25:16]));
    check("moves", 32'(m), 32'(nMoves));
    runFrom(10'h065, 1'b0);
    bus(seq_pkg::REG_CTRL, 1'b1, 32'h00000004, r);
    bus(seq_pkg::REG_STATUS, 1'b0, 32'h0, r);
    check("aborted", 32'h0, 32'(r[2:0]));
    latency <= 8'h1E;
    runFrom(10'h1F4, 1'b1);
    waitEv(0, n);
    checkMove(7'h50, 32'h5F5E0FF, 32'hFA0, 32'h0, 32'h64, 32'h28);
    waitEv(2, n);
    check("tag", 32'h52, 32'(mcode));
    waitEv(3, n);
    bus(seq_pkg::REG_STATUS, 1'b0, 32'h0, r);
    check("counter", 32'h1F5, 32'(r[25:16]));
    bus(seq_pkg::REG_CTRL, 1'b0, 32'h0, r);
    check("axis", 32'h2, r);
    testDone();
  end
endmodule : testbench
